// [boc_act_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Actuator on the far side: a pump that only sees line edges
module boc_act_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic line_i,
  output logic [31:0] edges_o,
  output logic [31:0] half_o
);
  logic last_r;
  logic [31:0] cnt_r;
  // Half period is the cycle count between two line changes
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      last_r <= 1'b0;
      cnt_r <= 32'h0;
      edges_o <= 32'h0;
      half_o <= 32'h0;
    end else begin
      last_r <= line_i;
      if (line_i !== last_r) begin
        edges_o <= edges_o + 32'h1;
        half_o <= cnt_r + 32'h1;
        cnt_r <= 32'h0;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [boc_binary_out.sv]
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module boc_binary_out import boc_pkg::*; #(
  parameter int unsigned CLK_HZ = PFM_CLK_HZ
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic hold_i,
  input wire logic error_i,
  input wire logic [15:0] sensor_val_i,
  input wire logic [15:0] binin_val_i,
  input wire logic [15:0] fbus_val_i,
  input wire logic [15:0] math_val_i,
  input wire logic [15:0] ctrl_raise_i,
  input wire logic [15:0] ctrl_lower_i,
  input wire logic [7:0] limit_sw_i,
  input wire logic [7:0] clean_sig_i,
  input wire logic individually_mapped_messages_i,
  input wire logic [3:0] namur_act_i,
  output logic out_o
);
  if (CLK_HZ < 2000) begin : g_chk
    $error("boc_binary_out: clock too slow for the top pulse rate");
  end

  // Configuration registers
  logic en_r, en_nxt;
  boc_sig_t type_r, type_nxt;
  boc_src_t src_r, src_nxt;
  boc_act_t act_r, act_nxt;
  boc_hold_t hold_r, hold_nxt;
  boc_err_t err_r, err_nxt;
  boc_func_t func_r, func_nxt;
  boc_diag_t diag_r, diag_nxt;
  logic [16:0] maxf_r, maxf_nxt;
  logic [6:0] holdv_r, holdv_nxt;
  logic [6:0] errv_r, errv_nxt;
  logic [7:0] lims_r, lims_nxt;
  logic [7:0] clns_r, clns_nxt;
  // Datapath state
  logic [15:0] val_r, val_nxt, src_val;
  logic bit_r, bit_nxt, st_bit;
  logic out_r, out_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [16:0] bip_sum;
  logic [16:0] wr_maxf;

  boc_pfm_if pfm_if ();

  // Register writes; out-of-range frequency and percent values clamp to the nearest bound
  always_comb begin
    en_nxt = en_r;
    type_nxt = type_r;
    src_nxt = src_r;
    act_nxt = act_r;
    hold_nxt = hold_r;
    err_nxt = err_r;
    func_nxt = func_r;
    diag_nxt = diag_r;
    maxf_nxt = maxf_r;
    holdv_nxt = holdv_r;
    errv_nxt = errv_r;
    lims_nxt = lims_r;
    clns_nxt = clns_r;
    wr_maxf = wdata_i[16:0];
    if (wr_i) begin
      unique case (addr_i)
        OFS_CTRL: begin
          en_nxt = wdata_i[CTRL_EN_BIT];
          type_nxt = boc_sig_t'(wdata_i[CTRL_TYPE_BIT]);
          src_nxt = boc_src_t'(wdata_i[CTRL_SRC_LSB +: 3]);
          act_nxt = boc_act_t'(wdata_i[CTRL_ACT_LSB +: 2]);
          hold_nxt = boc_hold_t'(wdata_i[CTRL_HOLD_LSB +: 2]);
          err_nxt = boc_err_t'(wdata_i[CTRL_ERR_BIT]);
          func_nxt = boc_func_t'(wdata_i[CTRL_FUNC_LSB +: 2]);
          diag_nxt = boc_diag_t'(wdata_i[CTRL_DIAG_LSB +: 3]);
        end
        OFS_MAXF: begin
          if (|wdata_i[31:17] || wr_maxf > MAXF_MAX_CHZ) begin
            maxf_nxt = MAXF_MAX_CHZ;
          end else if (wr_maxf < MAXF_MIN_CHZ) begin
            maxf_nxt = MAXF_MIN_CHZ;
          end else begin
            maxf_nxt = wr_maxf;
          end
        end
        OFS_HOLD: begin
          holdv_nxt = (|wdata_i[31:7] || wdata_i[6:0] > PCT_MAX) ? PCT_MAX : wdata_i[6:0];
        end
        OFS_ERRV: begin
          errv_nxt = (|wdata_i[31:7] || wdata_i[6:0] > PCT_MAX) ? PCT_MAX : wdata_i[6:0];
        end
        OFS_LIMS: lims_nxt = wdata_i[7:0];
        OFS_CLNS: clns_nxt = wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Factory defaults: on, static, sources none, freeze on hold, fixed on error
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      en_r <= 1'b1;
      type_r <= SIG_STATIC;
      src_r <= SRC_NONE;
      act_r <= ACT_NONE;
      hold_r <= HOLD_FREEZE;
      err_r <= ERR_FIXED;
      func_r <= FN_NONE;
      diag_r <= DG_INDIV;
      maxf_r <= MAXF_RST_CHZ;
      holdv_r <= HOLD_RST_PCT;
      errv_r <= ERR_RST_PCT;
      lims_r <= 8'h00;
      clns_r <= 8'h00;
    end else if (ce_i) begin
      en_r <= en_nxt;
      type_r <= type_nxt;
      src_r <= src_nxt;
      act_r <= act_nxt;
      hold_r <= hold_nxt;
      err_r <= err_nxt;
      func_r <= func_nxt;
      diag_r <= diag_nxt;
      maxf_r <= maxf_nxt;
      holdv_r <= holdv_nxt;
      errv_r <= errv_nxt;
      lims_r <= lims_nxt;
      clns_r <= clns_nxt;
    end
  end

  // Static switching state from limit switches, diagnostics or cleaning
  boc_static_sel u_sel (
    .func_i(func_r),
    .diag_i(diag_r),
    .limit_sw_i(limit_sw_i),
    .lim_sel_i(lims_r),
    .clean_sig_i(clean_sig_i),
    .cln_sel_i(clns_r),
    .diag_msg_i(individually_mapped_messages_i),
    .namur_act_i(namur_act_i),
    .bit_o(st_bit)
  );

  // Split range: both parts add, saturating at the top
  assign bip_sum = {1'b0, ctrl_raise_i} + {1'b0, ctrl_lower_i};

  // Pulse source value; unused codes fall back to none
  always_comb begin
    src_val = 16'h0000;
    unique case (src_r)
      SRC_NONE: src_val = 16'h0000;
      SRC_SENSOR: src_val = sensor_val_i;
      SRC_BININ: src_val = binin_val_i;
      SRC_FBUS: src_val = fbus_val_i;
      SRC_MATH: src_val = math_val_i;
      SRC_CTRL: begin
        unique case (act_r)
          ACT_NONE: src_val = 16'h0000;
          ACT_UNI_POS: src_val = ctrl_raise_i;
          ACT_UNI_NEG: src_val = ctrl_lower_i;
          ACT_BIPOLAR: src_val = bip_sum[16] ? FULL_SCALE : bip_sum[15:0];
        endcase
      end
      default: src_val = 16'h0000;
    endcase
  end

  // Error outranks hold; freezing just keeps the registered value
  always_comb begin
    val_nxt = src_val;
    bit_nxt = st_bit;
    if (error_i) begin
      if (err_r == ERR_FIXED) begin
        val_nxt = boc_pct2val(errv_r);
        bit_nxt = errv_r >= PCT_HALF;
      end else begin
        val_nxt = val_r;
        bit_nxt = bit_r;
      end
    end else if (hold_i) begin
      unique case (hold_r)
        HOLD_FIXED: begin
          val_nxt = boc_pct2val(holdv_r);
          bit_nxt = holdv_r >= PCT_HALF;
        end
        HOLD_IGNORE: ;
        default: begin
          val_nxt = val_r;
          bit_nxt = bit_r;
        end
      endcase
    end
    // Off gates the line but the tracked value keeps running
    out_nxt = 1'b0;
    if (en_r) begin
      out_nxt = (type_r == SIG_PFM) ? pfm_if.lvl : bit_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      val_r <= 16'h0000;
      bit_r <= 1'b0;
      out_r <= 1'b0;
    end else if (ce_i) begin
      val_r <= val_nxt;
      bit_r <= bit_nxt;
      out_r <= out_nxt;
    end
  end

  // Pulse generator runs only when enabled in pulse mode
  assign pfm_if.run = en_r && type_r == SIG_PFM;
  assign pfm_if.maxf = maxf_r;
  assign pfm_if.val = val_r;

  boc_pfm_gen #(
    .CLK_HZ(CLK_HZ),
    .ACC_W(52)
  ) u_pfm (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pfm(pfm_if.gen)
  );

  // Read data stands one cycle, zero otherwise and for unmapped offsets
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        OFS_CTRL: begin
          rdata_nxt[CTRL_EN_BIT] = en_r;
          rdata_nxt[CTRL_TYPE_BIT] = type_r;
          rdata_nxt[CTRL_SRC_LSB +: 3] = src_r;
          rdata_nxt[CTRL_ACT_LSB +: 2] = act_r;
          rdata_nxt[CTRL_HOLD_LSB +: 2] = hold_r;
          rdata_nxt[CTRL_ERR_BIT] = err_r;
          rdata_nxt[CTRL_FUNC_LSB +: 2] = func_r;
          rdata_nxt[CTRL_DIAG_LSB +: 3] = diag_r;
        end
        OFS_MAXF: rdata_nxt[16:0] = maxf_r;
        OFS_HOLD: rdata_nxt[6:0] = holdv_r;
        OFS_ERRV: rdata_nxt[6:0] = errv_r;
        OFS_LIMS: rdata_nxt[7:0] = lims_r;
        OFS_CLNS: rdata_nxt[7:0] = clns_r;
        OFS_STAT: begin
          rdata_nxt[0] = out_r;
          rdata_nxt[1] = bit_r;
          rdata_nxt[2] = pfm_if.lvl;
          rdata_nxt[STAT_VAL_LSB +: 16] = val_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign out_o = out_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Quiet line: enabled static path with no hold and no error
  sequence s_static_live;
    ce_i && en_r && type_r == SIG_STATIC && !hold_i && !error_i;
  endsequence

  a_off_forces_low: assert property (
    ce_i && !en_r |=> !out_o)
    else $error("output high while switched off");
  a_static_limit_or: assert property (
    s_static_live and func_r == FN_LIMIT |=> out_o == $past(|(limit_sw_i & lims_r)))
    else $error("limit switch state not transmitted");
  a_static_clean_or: assert property (
    s_static_live and func_r == FN_CLEAN |=> out_o == $past(|(clean_sig_i & clns_r)))
    else $error("cleaning signal not transmitted");
  a_func_none_off: assert property (
    s_static_live and func_r == FN_NONE |=> !out_o)
    else $error("static function none but output high");
  a_diag_class_sel: assert property (
    s_static_live and func_r == FN_DIAG && diag_r == DG_F |=> out_o == $past(namur_act_i[3]))
    else $error("class F diagnostics not transmitted");
  a_err_fixed_val: assert property (
    ce_i && error_i && err_r == ERR_FIXED |=> val_r == boc_pct2val($past(errv_r)))
    else $error("error value not applied");
  a_hold_freeze_val: assert property (
    ce_i && hold_i && !error_i && hold_r == HOLD_FREEZE |=> $stable(val_r) && $stable(bit_r))
    else $error("value moved during frozen hold");
  a_src_none_zero: assert property (
    ce_i && !hold_i && !error_i && src_r == SRC_NONE |=> val_r == 16'h0000)
    else $error("source none but nonzero value");
  a_ctrl_raise_only: assert property (
    ce_i && !hold_i && !error_i && src_r == SRC_CTRL && act_r == ACT_UNI_POS
    |=> val_r == $past(ctrl_raise_i))
    else $error("raise part not selected");
  a_maxf_in_range: assert property (
    maxf_r >= MAXF_MIN_CHZ && maxf_r <= MAXF_MAX_CHZ)
    else $error("maximum frequency out of range");
  a_pfm_to_line: assert property (
    ce_i && en_r && type_r == SIG_PFM |=> out_o == $past(pfm_if.lvl))
    else $error("pulse level not on output");

  c_pfm_toggle: cover property (type_r == SIG_PFM && $rose(out_o));
  c_hold_fixed: cover property (hold_i && hold_r == HOLD_FIXED && ce_i);
  c_err_freeze: cover property (error_i && err_r == ERR_FREEZE && ce_i);
  c_limit_on: cover property (s_static_live and func_r == FN_LIMIT ##1 out_o);
endmodule
`default_nettype wire

// [boc_pfm_gen.sv]
`timescale 1ns/100ps
`default_nettype none
module boc_pfm_gen import boc_pkg::*; #(
  parameter int unsigned CLK_HZ = PFM_CLK_HZ,
  parameter int unsigned ACC_W = 52
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  boc_pfm_if.gen pfm
);
  // Half a pulse period in accumulator units, at full scale
  localparam longint unsigned HALF = CHZ_PER_HZ * longint'(CLK_HZ) * 65535 / 2;

  // Twice the threshold must fit, or the accumulator wraps before it toggles
  if (ACC_W < 52 || CLK_HZ < 2000 || ((2 * HALF) >> ACC_W) != 0) begin : g_chk
    $error("boc_pfm_gen: accumulator too narrow or clock too slow");
  end

  logic [ACC_W-1:0] acc_r, acc_nxt, sum;
  logic lvl_r, lvl_nxt;

  // Phase accumulator: rate is linear in val, top equals maxf
  always_comb begin
    sum = acc_r + ACC_W'(pfm.maxf) * ACC_W'(pfm.val);
    acc_nxt = sum;
    lvl_nxt = lvl_r;
    if (!pfm.run) begin
      acc_nxt = '0;
      lvl_nxt = 1'b0;
    end else if (sum >= ACC_W'(HALF)) begin
      acc_nxt = sum - ACC_W'(HALF);
      lvl_nxt = ~lvl_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      acc_r <= '0;
      lvl_r <= 1'b0;
    end else if (ce_i) begin
      acc_r <= acc_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign pfm.lvl = lvl_r;

  a_pfm_zero_rate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pfm.run && pfm.val == 16'h0000 && acc_r < ACC_W'(HALF) |=> $stable(lvl_r))
    else $error("pulse edge with zero value");
  a_pfm_idle_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !pfm.run && ce_i |=> !lvl_r)
    else $error("pulse level high while stopped");
endmodule
`default_nettype wire

// [boc_pfm_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface boc_pfm_if;
  logic run;
  logic [16:0] maxf;
  logic [15:0] val;
  logic lvl;
  modport ctl (output run, output maxf, output val, input lvl);
  modport gen (input run, input maxf, input val, output lvl);
endinterface
`default_nettype wire

// [boc_pkg.sv]
`default_nettype none
package boc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAXF = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_ERRV = 8'h0c;
  localparam logic [7:0] OFS_LIMS = 8'h10;
  localparam logic [7:0] OFS_CLNS = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Control word field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TYPE_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_ACT_LSB = 5;
  localparam int CTRL_HOLD_LSB = 7;
  localparam int CTRL_ERR_BIT = 9;
  localparam int CTRL_FUNC_LSB = 10;
  localparam int CTRL_DIAG_LSB = 12;
  localparam int STAT_VAL_LSB = 16;
  // Frequency limits in hundredths of a hertz; clock rate in hertz
  localparam logic [16:0] MAXF_MIN_CHZ = 17'h00064;
  localparam logic [16:0] MAXF_MAX_CHZ = 17'h186a0;
  localparam logic [16:0] MAXF_RST_CHZ = 17'h186a0;
  localparam longint unsigned CHZ_PER_HZ = 100;
  localparam int unsigned PFM_CLK_HZ = 200000000;
  // Percent values and value scale
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [6:0] PCT_HALF = 7'h32;
  localparam logic [6:0] HOLD_RST_PCT = 7'h00;
  localparam logic [6:0] ERR_RST_PCT = 7'h00;
  localparam logic [15:0] PCT_STEP = 16'h028f;
  localparam logic [15:0] FULL_SCALE = 16'hffff;

  typedef enum logic {SIG_STATIC = 1'b0, SIG_PFM = 1'b1} boc_sig_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_SENSOR = 3'b001, SRC_BININ = 3'b010,
    SRC_CTRL = 3'b011, SRC_FBUS = 3'b100, SRC_MATH = 3'b101
  } boc_src_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_BIPOLAR = 2'b01, ACT_UNI_POS = 2'b10, ACT_UNI_NEG = 2'b11
  } boc_act_t;
  typedef enum logic [1:0] {
    HOLD_FREEZE = 2'b00, HOLD_FIXED = 2'b01, HOLD_IGNORE = 2'b10
  } boc_hold_t;
  typedef enum logic {ERR_FREEZE = 1'b0, ERR_FIXED = 1'b1} boc_err_t;
  typedef enum logic [1:0] {
    FN_NONE = 2'b00, FN_LIMIT = 2'b01, FN_DIAG = 2'b10, FN_CLEAN = 2'b11
  } boc_func_t;
  typedef enum logic [2:0] {
    DG_INDIV = 3'b000, DG_M = 3'b001, DG_S = 3'b010, DG_C = 3'b011, DG_F = 3'b100
  } boc_diag_t;

  // Percent to full-scale value; 100 % maps exactly to the top
  function automatic logic [15:0] boc_pct2val(input logic [6:0] pct);
    logic [15:0] v;
    v = 16'(pct) * PCT_STEP;
    if (pct >= PCT_MAX) v = FULL_SCALE;
    return v;
  endfunction
endpackage
`default_nettype wire

// [boc_static_sel.sv]
`timescale 1ns/100ps
`default_nettype none
module boc_static_sel import boc_pkg::*; (
  input wire boc_func_t func_i,
  input wire boc_diag_t diag_i,
  input wire logic [7:0] limit_sw_i,
  input wire logic [7:0] lim_sel_i,
  input wire logic [7:0] clean_sig_i,
  input wire logic [7:0] cln_sel_i,
  input wire logic diag_msg_i,
  input wire logic [3:0] namur_act_i,
  output logic bit_o
);
  logic diag_bit;

  // Diagnostic message pick: own mapping or one whole class
  always_comb begin
    diag_bit = 1'b0;
    unique case (diag_i)
      DG_INDIV: diag_bit = diag_msg_i;
      DG_M: diag_bit = namur_act_i[0];
      DG_S: diag_bit = namur_act_i[1];
      DG_C: diag_bit = namur_act_i[2];
      DG_F: diag_bit = namur_act_i[3];
      default: diag_bit = 1'b0;
    endcase
  end

  // Any selected source active drives the contact
  always_comb begin
    bit_o = 1'b0;
    unique case (func_i)
      FN_NONE: bit_o = 1'b0;
      FN_LIMIT: bit_o = |(limit_sw_i & lim_sel_i);
      FN_DIAG: bit_o = diag_bit;
      FN_CLEAN: bit_o = |(clean_sig_i & cln_sel_i);
    endcase
  end
endmodule
`default_nettype wire

// [test_binary_output_channel.sv]
`timescale 1ns/100ps
`default_nettype none
module test_binary_output_channel;
  import boc_pkg::*;
  // Slow generator clock scale keeps pulse periods short in simulation
  localparam int unsigned CLKF = 1000000;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic hold_i = 1'b0;
  logic error_i = 1'b0;
  logic imm_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] lsw = 8'h00;
  logic [7:0] cln = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [15:0] sv [0:5] = '{16'h0, 16'hffff, 16'h8000, 16'ha000, 16'h4000, 16'hc000};
  logic [15:0] clower = 16'h6000;
  logic [3:0] namur = 4'h0;
  logic [31:0] rdata_o;
  logic out_o;
  logic [31:0] edges;
  logic [31:0] half;
  int err_count = 0;
  int checked = 0;

  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  boc_binary_out #(.CLK_HZ(CLKF)) u_boc_binary_out (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .hold_i(hold_i), .error_i(error_i), .sensor_val_i(sv[1]), .binin_val_i(sv[2]),
    .fbus_val_i(sv[4]), .math_val_i(sv[5]), .ctrl_raise_i(sv[3]),
    .ctrl_lower_i(clower), .limit_sw_i(lsw), .clean_sig_i(cln),
    .individually_mapped_messages_i(imm_i), .namur_act_i(namur), .out_o(out_o));

  boc_act_model u_boc_act_model (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .line_i(out_o), .edges_o(edges), .half_o(half));

  task automatic stop_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] cw(input logic on, input logic typ, input logic [2:0] src,
      input logic [1:0] act, input logic [1:0] hb, input logic eb, input logic [1:0] fn,
      input logic [2:0] dg);
    return 32'(on) | (32'(typ) << CTRL_TYPE_BIT) | (32'(src) << CTRL_SRC_LSB) |
      (32'(act) << CTRL_ACT_LSB) | (32'(hb) << CTRL_HOLD_LSB) | (32'(eb) << CTRL_ERR_BIT) |
      (32'(fn) << CTRL_FUNC_LSB) | (32'(dg) << CTRL_DIAG_LSB);
  endfunction

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data exists only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  // Static line after the config and input paths settle
  task automatic st(input logic e);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk(32'(out_o), 32'(e));
    // Return on an edge so the caller's next inputs change there
    @(posedge ref_clk_i);
  endtask

  // Pulse half period from the actuator, or no edges when v is zero
  task automatic pfm(input longint unsigned maxf, input longint unsigned v);
    logic [31:0] e0;
    int n;
    longint unsigned h;
    repeat (20) @(posedge ref_clk_i);
    #1;
    e0 = edges;
    n = 0;
    if (v == 0) begin
      repeat (3000) @(posedge ref_clk_i);
      #1;
      chk(edges, e0);
    end else begin
      // Counters are read after the edge that updates them
      while (edges < e0 + 3 && n < 20000) begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      if (n >= 20000) begin
        err_count++;
        stop_test();
      end
      h = longint'(CLKF) * 100 * 65535 / (2 * maxf * v);
      chk(32'(half + 2 >= h && half <= h + 2), 32'h1);
    end
  endtask

  initial begin
    #450000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rdc(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 0, 0));
    rdc(OFS_MAXF, 32'(MAXF_RST_CHZ));
    rdc(OFS_HOLD, 32'h0);
    rdc(OFS_ERRV, 32'h0);
    rdc(8'h1c, 32'h0);
    st(1'b0);
    wr(OFS_MAXF, 32'h0);
    rdc(OFS_MAXF, 32'h64);
    wr(OFS_MAXF, 32'h1ffff);
    rdc(OFS_MAXF, 32'h186a0);
    // Strobes while the clock enable is low are lost
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    wr(OFS_LIMS, 32'hff);
    ce_i <= 1'b1;
    rdc(OFS_LIMS, 32'h0);
    // Limit switches combine as OR of the selected ones
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 1, 0));
    wr(OFS_LIMS, 32'h05);
    lsw <= 8'h04;
    st(1'b1);
    rdc(OFS_STAT, 32'h3);
    lsw <= 8'h02;
    st(1'b0);
    lsw <= 8'h01;
    st(1'b1);
    wr(OFS_CTRL, cw(0, 0, 0, 0, 0, 1, 1, 0));
    st(1'b0);
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 1, 0));
    hold_i <= 1'b1;
    st(1'b1);
    lsw <= 8'h00;
    st(1'b1);
    hold_i <= 1'b0;
    st(1'b0);
    wr(OFS_HOLD, 32'h64);
    wr(OFS_CTRL, cw(1, 0, 0, 0, 1, 1, 1, 0));
    hold_i <= 1'b1;
    st(1'b1);
    wr(OFS_CTRL, cw(1, 0, 0, 0, 2, 1, 1, 0));
    st(1'b0);
    hold_i <= 1'b0;
    lsw <= 8'h01;
    error_i <= 1'b1;
    st(1'b0);
    wr(OFS_ERRV, 32'hff);
    rdc(OFS_ERRV, 32'h64);
    st(1'b1);
    error_i <= 1'b0;
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 0, 1, 0));
    st(1'b1);
    error_i <= 1'b1;
    lsw <= 8'h00;
    st(1'b1);
    error_i <= 1'b0;
    st(1'b0);
    lsw <= 8'h01;
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 0, 0));
    st(1'b0);
    // Cleaning program signals
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 3, 0));
    wr(OFS_CLNS, 32'h80);
    cln <= 8'h80;
    st(1'b1);
    cln <= 8'h7f;
    st(1'b0);
    // Diagnostics: mapped messages, then each class in turn
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 2, 0));
    imm_i <= 1'b1;
    st(1'b1);
    imm_i <= 1'b0;
    st(1'b0);
    for (int k = 1; k <= 4; k++) begin
      wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 1, 2, 3'(k)));
      namur <= 4'h1 << (k - 1);
      st(1'b1);
      namur <= ~(4'h1 << (k - 1));
      st(1'b0);
    end
    // Pulse mode, each source carries a distinct value
    wr(OFS_MAXF, 32'h186a0);
    for (int s = 0; s <= 5; s++) begin
      wr(OFS_CTRL, cw(1, 1, 3'(s), 2, 0, 1, 0, 0));
      pfm(100000, sv[s]);
    end
    wr(OFS_CTRL, cw(1, 1, 3, 3, 0, 1, 0, 0));
    pfm(100000, clower);
    wr(OFS_CTRL, cw(1, 1, 3, 1, 0, 1, 0, 0));
    pfm(100000, 16'hffff);
    wr(OFS_CTRL, cw(1, 1, 3, 0, 0, 1, 0, 0));
    pfm(100000, 0);
    wr(OFS_MAXF, 32'hc350);
    wr(OFS_CTRL, cw(1, 1, 1, 0, 0, 1, 0, 0));
    pfm(50000, 16'hffff);
    stop_test();
  end
endmodule
`default_nettype wire
